//--- core/gti_timer.sv
// Guard timer with watchdog and interval modes and write-guarded registers
`timescale 1ns/100ps
module gti_timer
    import gti_pkg::*;
#(
    parameter int PRE_W = GTI_PRE_W
) (
    input wire logic clk,
    input wire logic rst_b,
    input wire logic [15:0] bus_addr,
    input wire logic [GTI_DATA_W-1:0] bus_wdata,
    input wire logic bus_wr,
    input wire logic bus_rd,
    output logic [GTI_DATA_W-1:0] bus_rdata,
    output logic irq_req,
    output logic wdt_reset
);
    logic tick;
    logic [7:0] cnt_reg, cnt_next;
    logic run_reg, run_next;
    logic rflag_reg, rflag_next;
    logic cnt_unl_reg, cnt_unl_next;
    logic ctl_unl_reg, ctl_unl_next;
    logic oflow_reg, oflow_next;
    logic mode_unl_reg, mode_unl_next;
    logic imode_reg, imode_next;
    logic ie_reg, ie_next;
    logic [GTI_SEL_W-1:0] sel_reg, sel_next;
    logic rst_pulse_reg, rst_pulse_next;
    logic [GTI_DATA_W-1:0] rdata_reg, rdata_next;
    logic wr_a, wr_b, wr_cnt, wr_sel, cnt_load, wrap;

    // Count enable from the prescaler
    gti_prescaler #(
        .PRE_W(PRE_W)
    ) u_prescaler (
        .clk(clk),
        .rst_b(rst_b),
        .sel(sel_reg),
        .tick(tick)
    );

    // Address decode; the alias shares the counter itself
    assign wr_a = bus_wr && (bus_addr == GTI_ADDR_CSA);
    assign wr_b = bus_wr && (bus_addr == GTI_ADDR_CSB);
    assign wr_cnt = bus_wr && ((bus_addr == GTI_ADDR_CNT) ||
                               (bus_addr == GTI_ADDR_ALIAS));
    assign wr_sel = bus_wr && (bus_addr == GTI_ADDR_SEL);
    assign cnt_load = wr_cnt && cnt_unl_reg;
    // A preload in the wrap cycle wins, so that cycle has no overflow
    assign wrap = run_reg && tick && !cnt_load &&
                  (cnt_reg == GTI_CNT_MAX);

    // Next state of counter, flags and control bits
    always_comb begin
        cnt_next = cnt_reg;
        run_next = run_reg;
        rflag_next = rflag_reg;
        cnt_unl_next = cnt_unl_reg;
        ctl_unl_next = ctl_unl_reg;
        oflow_next = oflow_reg;
        mode_unl_next = mode_unl_reg;
        imode_next = imode_reg;
        ie_next = ie_reg;
        sel_next = sel_reg;
        rst_pulse_next = 1'b0;
        // Counter: software preload, else count on each enable while running
        if (cnt_load) begin
            cnt_next = bus_wdata;
        end else if (run_reg && tick) begin
            cnt_next = cnt_reg + GTI_CNT_ONE;
        end
        // Register A: each companion bit moves only with its guard at zero
        if (wr_a && !bus_wdata[GTI_A_CNT_GUARD]) begin
            cnt_unl_next = bus_wdata[GTI_A_CNT_UNLOCK];
        end
        if (wr_a && !bus_wdata[GTI_A_CTL_GUARD]) begin
            ctl_unl_next = bus_wdata[GTI_A_CTL_UNLOCK];
        end
        if (wr_a && ctl_unl_reg && !bus_wdata[GTI_A_RUN_GUARD]) begin
            run_next = bus_wdata[GTI_A_RUN];
        end
        // Reset flag: the overflow set wins over a clear in the same cycle
        if (wrap && !imode_reg) begin
            rflag_next = 1'b1;
            rst_pulse_next = 1'b1;
        end else if (wr_a && ctl_unl_reg &&
                     !bus_wdata[GTI_A_RFLAG_GUARD] &&
                     !bus_wdata[GTI_A_RFLAG]) begin
            rflag_next = 1'b0;
        end
        // Overflow flag: only a zero can be written, and the set wins
        if (wrap) begin
            oflow_next = 1'b1;
        end else if (wr_b && !bus_wdata[GTI_B_OFLOW]) begin
            oflow_next = 1'b0;
        end
        // Register B: mode needs a prior unlock write, hence two writes
        if (wr_b && !bus_wdata[GTI_B_MUNL_GUARD]) begin
            mode_unl_next = bus_wdata[GTI_B_MODE_UNLOCK];
        end
        if (wr_b && mode_unl_reg && !bus_wdata[GTI_B_MODE_GUARD]) begin
            imode_next = bus_wdata[GTI_B_MODE];
        end
        if (wr_b && !bus_wdata[GTI_B_IE_GUARD]) begin
            ie_next = bus_wdata[GTI_B_IE];
        end
        if (wr_sel) begin
            sel_next = bus_wdata[GTI_SEL_W-1:0];
        end
    end

    // Read data: guard bits read as one, stands only in the next cycle
    always_comb begin
        rdata_next = '0;
        if (bus_rd) begin
            unique case (bus_addr)
                GTI_ADDR_CSA: begin
                    rdata_next = {1'b1, cnt_unl_reg, 1'b1, ctl_unl_reg,
                                  1'b1, run_reg, 1'b1, rflag_reg};
                end
                GTI_ADDR_CSB: begin
                    rdata_next = {oflow_reg, 1'b1, mode_unl_reg, 1'b1,
                                  imode_reg, 1'b1, ie_reg, 1'b0};
                end
                GTI_ADDR_CNT, GTI_ADDR_ALIAS: begin
                    rdata_next = cnt_reg;
                end
                GTI_ADDR_SEL: begin
                    rdata_next = {{(GTI_DATA_W-GTI_SEL_W){1'b0}}, sel_reg};
                end
                default: begin
                    rdata_next = '0;
                end
            endcase
        end
    end

    // State registers; the pin reset clears the reset flag, as does a guarded zero write to register A while control is unlocked
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            cnt_reg <= GTI_CNT_RESET;
            run_reg <= 1'b0;
            rflag_reg <= 1'b0;
            cnt_unl_reg <= 1'b0;
            ctl_unl_reg <= 1'b0;
            oflow_reg <= 1'b0;
            mode_unl_reg <= 1'b0;
            imode_reg <= 1'b0;
            ie_reg <= 1'b0;
            sel_reg <= GTI_SEL_RESET;
            rst_pulse_reg <= 1'b0;
            rdata_reg <= '0;
        end else begin
            cnt_reg <= cnt_next;
            run_reg <= run_next;
            rflag_reg <= rflag_next;
            cnt_unl_reg <= cnt_unl_next;
            ctl_unl_reg <= ctl_unl_next;
            oflow_reg <= oflow_next;
            mode_unl_reg <= mode_unl_next;
            imode_reg <= imode_next;
            ie_reg <= ie_next;
            sel_reg <= sel_next;
            rst_pulse_reg <= rst_pulse_next;
            rdata_reg <= rdata_next;
        end
    end

    // Outputs; the request is a level, software must clear the flag
    assign irq_req = oflow_reg && ie_reg;
    assign wdt_reset = rst_pulse_reg;
    assign bus_rdata = rdata_reg;

    // Checks
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_b);

    sequence s_unlock_ctl;
        wr_a && !bus_wdata[GTI_A_CTL_GUARD] && bus_wdata[GTI_A_CTL_UNLOCK];
    endsequence

    sequence s_start_run;
        wr_a && !bus_wdata[GTI_A_RUN_GUARD] && bus_wdata[GTI_A_RUN];
    endsequence

    sequence s_unlock_mode;
        wr_b && !bus_wdata[GTI_B_MUNL_GUARD] &&
        bus_wdata[GTI_B_MODE_UNLOCK];
    endsequence

    sequence s_set_mode;
        wr_b && !bus_wdata[GTI_B_MODE_GUARD] && bus_wdata[GTI_B_MODE];
    endsequence

    a_wrap_sets_ovf: assert property (
        run_reg && tick && !cnt_load && cnt_reg == GTI_CNT_MAX
        |=> oflow_reg && cnt_reg == GTI_CNT_RESET)
        else $error("overflow flag not set on counter wrap");

    a_preload_taken: assert property (
        wr_cnt && cnt_unl_reg |=> cnt_reg == $past(bus_wdata))
        else $error("counter preload not taken");

    a_counter_locked: assert property (
        wr_cnt && !cnt_unl_reg && !(run_reg && tick)
        |=> $stable(cnt_reg))
        else $error("locked counter changed by a write");

    a_wdog_reset: assert property (
        wrap && !imode_reg |=> wdt_reset && rflag_reg ##1 !wdt_reset)
        else $error("watchdog overflow gave no one-cycle reset");

    a_interval_quiet: assert property (
        wrap && imode_reg |=> !wdt_reset && oflow_reg)
        else $error("interval overflow misbehaved");

    a_run_two_writes: assert property (
        s_unlock_ctl ##1 s_start_run |=> run_reg)
        else $error("two-write start did not run the counter");

    a_mode_two_writes: assert property (
        s_unlock_mode ##1 s_set_mode |=> imode_reg)
        else $error("two-write mode select failed");

    a_run_guarded: assert property (
        wr_a && bus_wdata[GTI_A_RUN_GUARD] |=> $stable(run_reg))
        else $error("run bit changed with guard set");

    a_run_stop: assert property (
        wr_a && ctl_unl_reg && !bus_wdata[GTI_A_RUN_GUARD] &&
        !bus_wdata[GTI_A_RUN] |=> !run_reg ##1 ($stable(cnt_reg) ||
        $past(cnt_load)))
        else $error("run bit not cleared or counter kept counting");

    a_irq_follows: assert property (
        wrap && ie_reg && !wr_b |=> irq_req)
        else $error("interrupt not raised on overflow");

    a_irq_holds: assert property (
        irq_req && !wr_b && !wr_a |=> irq_req)
        else $error("interrupt level dropped without a clear");

    a_tick_period: assert property (
        tick && sel_reg == GTI_SEL_MIN && !wr_sel
        |-> ##64 (tick || sel_reg != GTI_SEL_MIN))
        else $error("shortest prescaler period wrong");
endmodule : gti_timer

//--- core/gti_pkg.sv
// Package with register map, field layout and constants of the guard timer
package gti_pkg;
    // Register byte addresses on the plain register port
    localparam logic [15:0] GTI_ADDR_CSA = 16'hFFB1;
    localparam logic [15:0] GTI_ADDR_CSB = 16'hFFB2;
    localparam logic [15:0] GTI_ADDR_CNT = 16'hFFB3;
    localparam logic [15:0] GTI_ADDR_SEL = 16'hFFB4;
    localparam logic [15:0] GTI_ADDR_ALIAS = 16'hFFB5;

    localparam int GTI_DATA_W = 8;
    localparam int GTI_SEL_W = 3;

    // Control/status A field positions
    localparam int GTI_A_CNT_GUARD = 7;
    localparam int GTI_A_CNT_UNLOCK = 6;
    localparam int GTI_A_CTL_GUARD = 5;
    localparam int GTI_A_CTL_UNLOCK = 4;
    localparam int GTI_A_RUN_GUARD = 3;
    localparam int GTI_A_RUN = 2;
    localparam int GTI_A_RFLAG_GUARD = 1;
    localparam int GTI_A_RFLAG = 0;

    // Control/status B field positions
    localparam int GTI_B_OFLOW = 7;
    localparam int GTI_B_MUNL_GUARD = 6;
    localparam int GTI_B_MODE_UNLOCK = 5;
    localparam int GTI_B_MODE_GUARD = 4;
    localparam int GTI_B_MODE = 3;
    localparam int GTI_B_IE_GUARD = 2;
    localparam int GTI_B_IE = 1;

    // Counter values
    localparam logic [7:0] GTI_CNT_RESET = 8'h00;
    localparam logic [7:0] GTI_CNT_MAX = 8'hFF;
    localparam logic [7:0] GTI_CNT_ONE = 8'h01;

    // Prescaler: select code k divides by two to the power (base + k)
    localparam int GTI_PRE_W = 13;
    localparam int GTI_DIV_BASE = 6;
    localparam int GTI_DIV_MIN = 64;
    localparam logic [2:0] GTI_SEL_RESET = 3'h7;
    localparam logic [2:0] GTI_SEL_MIN = 3'h0;
endpackage : gti_pkg

//--- core/gti_prescaler.sv
// Free-running prescaler that gives one-cycle count enables
`timescale 1ns/100ps
module gti_prescaler
    import gti_pkg::*;
#(
    parameter int PRE_W = GTI_PRE_W
) (
    input wire logic clk,
    input wire logic rst_b,
    input wire logic [GTI_SEL_W-1:0] sel,
    output logic tick
);
    logic [PRE_W-1:0] div_reg;
    logic [PRE_W-1:0] div_next;
    logic [PRE_W-1:0] mask;

    // Tick when all bits under the selected divide width are ones
    always_comb begin
        div_next = div_reg + PRE_W'(1);
        mask = ~({PRE_W{1'b1}} << (GTI_DIV_BASE + int'(sel)));
        tick = &(div_reg | ~mask);
    end

    // The prescaler never stops, so a new select takes effect at once
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            div_reg <= '0;
        end else begin
            div_reg <= div_next;
        end
    end
endmodule : gti_prescaler

//--- testbench/tb_top.sv
// Self-checking bench for the guard timer: registers, interval and watchdog
`timescale 1ns/100ps
module tb_top
    import gti_pkg::*;
;
    logic clk;
    logic rst_b;
    logic [15:0] bus_addr;
    logic [7:0] bus_wdata;
    logic bus_wr;
    logic bus_rd;
    logic [7:0] bus_rdata;
    logic irq_req;
    logic wdt_reset;
    logic [7:0] rd;
    int fails;
    int comparisons;
    int wdt_count;
    int n;

    gti_timer gti_timer_inst (.clk(clk), .rst_b(rst_b), .bus_addr(bus_addr),
        .bus_wdata(bus_wdata), .bus_wr(bus_wr), .bus_rd(bus_rd),
        .bus_rdata(bus_rdata), .irq_req(irq_req), .wdt_reset(wdt_reset));

    // Free-running 100 MHz clock
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    // Count cycles with the internal reset request high
    always @(posedge clk) begin
        if (wdt_reset === 1'b1) begin
            wdt_count++;
        end
    end

    task automatic check8(input string name, input logic [7:0] exp,
                          input logic [7:0] got);
        comparisons++;
        if (got !== exp) begin
            fails++;
            $display("[FAIL] %s expected %h seen %h", name, exp, got);
        end
    endtask : check8

    task automatic check_cnt(input string name, input int lo, input int hi,
                             input int got);
        comparisons++;
        if (got < lo || got > hi) begin
            fails++;
            $display("[FAIL] %s expected %0d..%0d seen %0d", name, lo, hi,
                     got);
        end
    endtask : check_cnt

    // One-cycle write; the strobe drops a full edge before any next request
    task automatic bus_write(input logic [15:0] a, input logic [7:0] d);
        @(posedge clk);
        bus_addr <= a;
        bus_wdata <= d;
        bus_wr <= 1'b1;
        @(posedge clk);
        bus_wr <= 1'b0;
    endtask : bus_write

    // Two writes back to back; the strobe stays high across both cycles
    task automatic bus_write2(input logic [15:0] a, input logic [7:0] d0,
                              input logic [7:0] d1);
        @(posedge clk);
        bus_addr <= a;
        bus_wdata <= d0;
        bus_wr <= 1'b1;
        @(posedge clk);
        bus_wdata <= d1;
        @(posedge clk);
        bus_wr <= 1'b0;
    endtask : bus_write2

    // Read data stand only in the cycle after the strobe
    task automatic bus_read(input logic [15:0] a, output logic [7:0] d);
        @(posedge clk);
        bus_addr <= a;
        bus_rd <= 1'b1;
        @(posedge clk);
        bus_rd <= 1'b0;
        #1;
        d = bus_rdata;
    endtask : bus_read

    // Bounded wait for the interrupt level; n gives the cycles spent
    task automatic wait_irq();
        n = 0;
        while (irq_req !== 1'b1 && n < 400) begin
            @(posedge clk);
            #1;
            n++;
        end
    endtask : wait_irq

    // Bounded wait until the reset pulse count reaches a target
    task automatic wait_wdt(input int target);
        n = 0;
        while (wdt_count < target && n < 300) begin
            @(posedge clk);
            #1;
            n++;
        end
    endtask : wait_wdt

    task automatic test_reset();
        bus_read(GTI_ADDR_CNT, rd);
        check8("cnt", 8'h00, rd);
        bus_read(GTI_ADDR_CSA, rd);
        check8("csa", 8'hAA, rd);
        // Read data must fall back to zero one cycle later
        @(posedge clk);
        #1;
        check8("rdata idle", 8'h00, bus_rdata);
        bus_read(GTI_ADDR_CSB, rd);
        check8("csb", 8'h54, rd);
        bus_read(GTI_ADDR_SEL, rd);
        check8("sel", 8'h07, rd);
        bus_read(16'h0000, rd);
        check8("unmapped", 8'h00, rd);
    endtask : test_reset

    // Writes refused while locked, accepted once unlocked
    task automatic test_lock();
        bus_write(GTI_ADDR_CSA, 8'hA6);
        bus_read(GTI_ADDR_CSA, rd);
        check8("run locked", 8'hAA, rd);
        bus_write(GTI_ADDR_CNT, 8'h12);
        bus_read(GTI_ADDR_CNT, rd);
        check8("cnt locked", 8'h00, rd);
        bus_write(GTI_ADDR_CSA, 8'h5A);
        bus_read(GTI_ADDR_CSA, rd);
        check8("unlock", 8'hFA, rd);
        bus_write(GTI_ADDR_ALIAS, 8'hFE);
        bus_read(GTI_ADDR_CNT, rd);
        check8("cnt", 8'hFE, rd);
        bus_read(GTI_ADDR_ALIAS, rd);
        check8("alias", 8'hFE, rd);
    endtask : test_lock

    // Interval mode: level interrupt, period, no system reset
    task automatic test_interval();
        bus_write(GTI_ADDR_SEL, 8'h00);
        // Unlock and select back to back, as software may do it
        bus_write2(GTI_ADDR_CSB, 8'h34, 8'h4A);
        bus_read(GTI_ADDR_CSB, rd);
        check8("mode", 8'h7E, rd);
        bus_write2(GTI_ADDR_CSA, 8'h5A, 8'hA6);
        wait_irq();
        check_cnt("first oflow", 1, 200, n);
        repeat (100) @(posedge clk);
        #1;
        check8("irq held", 8'h01, {7'h00, irq_req});
        bus_read(GTI_ADDR_CSB, rd);
        check8("oflow", 8'hFE, rd);
        bus_write(GTI_ADDR_CNT, 8'hFC);
        bus_write(GTI_ADDR_CSB, 8'h54);
        #1;
        check8("irq clr", 8'h00, {7'h00, irq_req});
        wait_irq();
        check_cnt("period", 188, 258, n);
        check_cnt("no reset", 0, 0, wdt_count);
    endtask : test_interval

    // Stopped counter holds its value
    task automatic test_stop();
        logic [7:0] first;
        bus_write(GTI_ADDR_CSA, 8'hA2);
        bus_read(GTI_ADDR_CNT, first);
        repeat (200) @(posedge clk);
        bus_read(GTI_ADDR_CNT, rd);
        check8("stopped", first, rd);
    endtask : test_stop

    // Watchdog mode: overflow gives a one-cycle reset and sets the flag
    task automatic test_watchdog();
        // Mode switch only while stopped
        bus_write(GTI_ADDR_CSB, 8'h40);
        bus_read(GTI_ADDR_CSB, rd);
        check8("wd mode", 8'h74, rd);
        bus_write(GTI_ADDR_CNT, 8'hFE);
        bus_write(GTI_ADDR_CSA, 8'hA6);
        wait_wdt(1);
        bus_write(GTI_ADDR_CSA, 8'hA2);
        check_cnt("wdt pulse", 1, 1, wdt_count);
        check8("irq off", 8'h00, {7'h00, irq_req});
        bus_read(GTI_ADDR_CSA, rd);
        check8("rflag", 8'h01, rd & 8'h01);
        bus_write(GTI_ADDR_CSA, 8'hA8);
        bus_read(GTI_ADDR_CSA, rd);
        check8("rflag clr", 8'h00, rd & 8'h01);
        // Second overflow, then a pin reset in mid-run clears everything but the select, which returns to 7
        bus_write(GTI_ADDR_CNT, 8'hFE);
        bus_write(GTI_ADDR_CSA, 8'hA6);
        wait_wdt(2);
        check_cnt("wdt again", 2, 2, wdt_count);
        @(posedge clk);
        rst_b <= 1'b0;
        repeat (2) @(posedge clk);
        rst_b <= 1'b1;
        bus_read(GTI_ADDR_CSA, rd);
        check8("pin reset", 8'hAA, rd);
        bus_read(GTI_ADDR_CNT, rd);
        check8("cnt cleared", 8'h00, rd);
    endtask : test_watchdog

    task automatic give_verdict();
        if (fails == 0 && comparisons > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask : give_verdict

    // Main sequence after five cycles of reset
    initial begin
        rst_b = 1'b0;
        bus_addr = 16'h0000;
        bus_wdata = 8'h00;
        bus_wr = 1'b0;
        bus_rd = 1'b0;
        repeat (5) @(posedge clk);
        rst_b <= 1'b1;
        test_reset();
        test_lock();
        test_interval();
        test_stop();
        test_watchdog();
        give_verdict();
    end

    // Watchdog: the tests need about 1000 cycles
    initial begin
        #200000;
        fails++;
        give_verdict();
    end
endmodule : tb_top
